// *** sdc_pkg.sv ***
package sdc_pkg;
   localparam int CLK_PS = 5000;
   localparam int ROW_COL_FAST_PS = 18000;
   localparam int ROW_COL_SLOW_PS = 19200;
   localparam int SR_EXIT_PS = 112500;
   localparam int REF_CYCLE_PS = 72000;
   localparam int T_RP_PS = 19200;
   localparam int T_RC_PS = 67500;
   localparam int T_REFI_PS = 7812500;
   localparam int REF_WINDOW_MS = 64;
   localparam int REF_ROWS = 8192;
   localparam int ROW_COL_PS = (ROW_COL_SLOW_PS > ROW_COL_FAST_PS) ?
      ROW_COL_SLOW_PS : ROW_COL_FAST_PS;
   localparam int ROW_COL_CYC = (ROW_COL_PS + CLK_PS - 1) / CLK_PS;
   localparam int SR_EXIT_CYC = (SR_EXIT_PS + CLK_PS - 1) / CLK_PS;
   localparam int REF_CYCLE_CYC = (REF_CYCLE_PS + CLK_PS - 1) / CLK_PS;
   localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
   localparam int RC_CYC = (T_RC_PS + CLK_PS - 1) / CLK_PS;
   localparam int REFI_CYC = T_REFI_PS / CLK_PS;
   localparam int ACT_GAP_CYC = 2;
   localparam int MODE_GAP_CYC = 2;
   localparam int WR_PRE_CYC = 2;
   localparam int LAST_WR_PRE_CYC = 2;
   localparam int WR_ACT_AUTO_CYC = 5;
   localparam int LAST_WR_COL_CYC = 1;
   localparam int COL_GAP_CYC = 1;
   localparam int MASK_FLOAT_CYC = 2;
   localparam int PRE_FLOAT_CYC = 3;
   localparam int CAS_LAT = 3;
   localparam int BA_W = 2;
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int DM_W = 2;
   localparam int ADDR_W = BA_W + ROW_W + COL_W;
   localparam int REQ_W = 1 + ADDR_W + DQ_W + DM_W;
   localparam int FIFO_D = 4;
   localparam int TMR_W = 16;
   localparam int AP_BIT = 10;
   localparam logic [ROW_W-1:0] MODE_VAL = 13'h0030;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MRS = 4'h0;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_INIT = 4'b0001,
      ST_PREA = 4'b0010,
      ST_IREF = 4'b0011,
      ST_MRS = 4'b0100,
      ST_ACT = 4'b0101,
      ST_RD = 4'b0110,
      ST_WR = 4'b0111,
      ST_REF = 4'b1000,
      ST_SR = 4'b1001,
      ST_WAIT = 4'b1010
   } sdc_state_type;
endpackage : sdc_pkg

// *** sdc_ctrl.sv ***
`timescale 1ns/10ps
module sdc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // Clock, enable and reset
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_q [D];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic rdy_q;
   logic in_fire;
   logic out_fire;

   assign in_fire = ce & in_valid & rdy_q;
   assign out_fire = ce & out_ready & out_valid;
   assign cnt_d = cnt_q + CW'(in_fire) - CW'(out_fire);
   assign in_ready = rdy_q;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];

   always_ff @(posedge core_clk) begin
      if (in_fire) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
      end else if (ce) begin
         if (in_fire) begin
            wp_q <= (wp_q == PW'(D - 1)) ? '0 : wp_q + 1'b1;
         end
         if (out_fire) begin
            rp_q <= (rp_q == PW'(D - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_d;
         // Registered so the ready port stays a flop output
         rdy_q <= (cnt_d != CW'(D));
      end
   end
endmodule : sdc_fifo

module sdc_ctrl
   import sdc_pkg::*;
#(
   parameter int INIT_WAIT_CYC = 20000
) (
   // Clock, enable, reset
   input wire logic core_clk,
   input wire logic ce,
   input wire logic arst_n,
   // User requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DQ_W-1:0] req_wdata,
   input wire logic [DM_W-1:0] req_mask,
   // Read answers
   output logic rd_valid,
   output logic [DQ_W-1:0] rd_data,
   // Power control
   input wire logic sr_req,
   output logic sr_active,
   output logic init_done,
   // Memory pins
   output logic sd_cke,
   output logic sd_cs_n,
   output logic sd_ras_n,
   output logic sd_cas_n,
   output logic sd_we_n,
   output logic [BA_W-1:0] sd_ba,
   output logic [ROW_W-1:0] sd_addr,
   output logic [DM_W-1:0] sd_dqm,
   output logic [DQ_W-1:0] sd_dq_out,
   output logic sd_dq_oe,
   input wire logic [DQ_W-1:0] sd_dq_in
);
   sdc_state_type state_q;
   sdc_state_type nxt_q;
   logic [TMR_W-1:0] tmr_q;
   logic [3:0] cmd_q;
   logic [BA_W-1:0] ba_q;
   logic [ROW_W-1:0] a_q;
   logic [DM_W-1:0] dqm_q;
   logic [DQ_W-1:0] dq_q;
   logic oe_q;
   logic cke_q;
   logic sr_q;
   logic done_q;
   logic iref_q;
   logic [REQ_W-1:0] fifo_data;
   logic fifo_valid;
   logic pop;
   logic cur_wr_q;
   logic [ADDR_W-1:0] cur_addr_q;
   logic [DQ_W-1:0] cur_wdata_q;
   logic [DM_W-1:0] cur_mask_q;
   logic [TMR_W-1:0] ref_tmr_q;
   logic ref_pend_q;
   logic ref_set;
   logic ref_clr;
   logic [CAS_LAT:0] rd_pipe_q;
   logic rd_valid_q;
   logic [DQ_W-1:0] rd_data_q;

   // Command gap g in cycles becomes a wait count; two is the floor
   // because a command state and one wait state always lie between
   function automatic logic [TMR_W-1:0] gap(input int g);
      gap = (g < 2) ? '0 : TMR_W'(g - 2);
   endfunction : gap

   // Closed-page spacing covers row cycle, write recovery and turnaround
   localparam int RW_NEXT = ((RC_CYC - ROW_COL_CYC) > WR_ACT_AUTO_CYC) ?
      (RC_CYC - ROW_COL_CYC) : WR_ACT_AUTO_CYC;

   sdc_fifo #(
      .W(REQ_W),
      .D(FIFO_D)
   ) sdc_fifo_inst (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .ce(ce),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_write, req_addr, req_wdata, req_mask}),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // Writes wait until read data has left the bus
   assign pop = ce && state_q == ST_IDLE && !ref_pend_q && !sr_req &&
      fifo_valid && (!fifo_data[REQ_W-1] || rd_pipe_q == '0);

   assign ref_clr = ce && (state_q == ST_REF || state_q == ST_SR);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_INIT;
         nxt_q <= ST_PREA;
         tmr_q <= TMR_W'(INIT_WAIT_CYC);
         cmd_q <= CMD_NOP;
         ba_q <= '0;
         a_q <= '0;
         dqm_q <= '1;
         dq_q <= '0;
         oe_q <= 1'b0;
         cke_q <= 1'b1;
         sr_q <= 1'b0;
         done_q <= 1'b0;
         iref_q <= 1'b0;
         cur_wr_q <= 1'b0;
         cur_addr_q <= '0;
         cur_wdata_q <= '0;
         cur_mask_q <= '0;
      end else if (ce) begin
         cmd_q <= CMD_NOP;
         oe_q <= 1'b0;
         // Held low on reads so all bytes drive two cycles on
         dqm_q <= '0;
         case (state_q)
            ST_INIT: begin
               if (tmr_q == '0) begin
                  state_q <= ST_PREA;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            ST_PREA: begin
               cmd_q <= CMD_PRE;
               a_q <= ROW_W'(1) << AP_BIT;
               tmr_q <= gap(RP_CYC);
               nxt_q <= ST_IREF;
               state_q <= ST_WAIT;
            end
            ST_IREF: begin
               cmd_q <= CMD_REF;
               iref_q <= 1'b1;
               tmr_q <= gap(REF_CYCLE_CYC);
               nxt_q <= iref_q ? ST_MRS : ST_IREF;
               state_q <= ST_WAIT;
            end
            ST_MRS: begin
               cmd_q <= CMD_MRS;
               ba_q <= '0;
               a_q <= MODE_VAL;
               tmr_q <= gap(MODE_GAP_CYC);
               nxt_q <= ST_IDLE;
               done_q <= 1'b1;
               state_q <= ST_WAIT;
            end
            ST_IDLE: begin
               if (ref_pend_q) begin
                  state_q <= ST_REF;
               end else if (sr_req) begin
                  state_q <= ST_SR;
               end else if (pop) begin
                  {cur_wr_q, cur_addr_q, cur_wdata_q, cur_mask_q} <=
                     fifo_data;
                  state_q <= ST_ACT;
               end
            end
            ST_ACT: begin
               cmd_q <= CMD_ACT;
               ba_q <= cur_addr_q[ADDR_W-1 -: BA_W];
               a_q <= cur_addr_q[COL_W +: ROW_W];
               // One access at a time keeps activates far apart
               tmr_q <= gap(ROW_COL_CYC > ACT_GAP_CYC ? ROW_COL_CYC :
                  ACT_GAP_CYC);
               nxt_q <= cur_wr_q ? ST_WR : ST_RD;
               state_q <= ST_WAIT;
            end
            ST_RD, ST_WR: begin
               cmd_q <= (state_q == ST_WR) ? CMD_WR : CMD_RD;
               a_q <= (ROW_W'(1) << AP_BIT) |
                  ROW_W'(cur_addr_q[COL_W-1:0]);
               // Data and mask ride on the write command edge
               dq_q <= cur_wdata_q;
               // Single-beat bursts end themselves; no stop is sent
               oe_q <= (state_q == ST_WR);
               if (state_q == ST_WR) begin
                  dqm_q <= cur_mask_q;
               end
               // Auto precharge replaces an explicit precharge
               tmr_q <= gap(RW_NEXT > WR_PRE_CYC + RP_CYC ? RW_NEXT :
                  WR_PRE_CYC + RP_CYC);
               nxt_q <= ST_IDLE;
               state_q <= ST_WAIT;
            end
            ST_REF: begin
               cmd_q <= CMD_REF;
               tmr_q <= gap(REF_CYCLE_CYC);
               nxt_q <= ST_IDLE;
               state_q <= ST_WAIT;
            end
            ST_SR: begin
               // Enter with refresh command and clock enable low
               if (!sr_q) begin
                  cmd_q <= CMD_REF;
                  cke_q <= 1'b0;
                  sr_q <= 1'b1;
               end else if (!sr_req) begin
                  cke_q <= 1'b1;
                  sr_q <= 1'b0;
                  // NOPs keep the clock running through the exit wait
                  tmr_q <= gap(SR_EXIT_CYC);
                  nxt_q <= ST_IDLE;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (tmr_q == '0) begin
                  state_q <= nxt_q;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Distributed refresh timer; a tick beats a same-cycle clear
   assign ref_set = (ref_tmr_q == '0) ||
      (state_q == ST_SR && sr_q && !sr_req);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_tmr_q <= TMR_W'(REFI_CYC - 1);
         ref_pend_q <= 1'b0;
      end else if (ce) begin
         ref_tmr_q <= (ref_tmr_q == '0) ? TMR_W'(REFI_CYC - 1) :
            ref_tmr_q - 1'b1;
         if (!done_q) begin
            ref_pend_q <= 1'b0;
         end else if (ref_set) begin
            ref_pend_q <= 1'b1;
         end else if (ref_clr) begin
            ref_pend_q <= 1'b0;
         end
      end
   end

   // Read data returns CAS latency after the command is on the pins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pipe_q <= '0;
         rd_valid_q <= 1'b0;
         rd_data_q <= '0;
      end else if (ce) begin
         rd_pipe_q <= {rd_pipe_q[CAS_LAT-1:0], state_q == ST_RD};
         rd_valid_q <= rd_pipe_q[CAS_LAT];
         if (rd_pipe_q[CAS_LAT]) begin
            rd_data_q <= sd_dq_in;
         end
      end
   end

   assign sd_cke = cke_q;
   assign sd_cs_n = cmd_q[3];
   assign sd_ras_n = cmd_q[2];
   assign sd_cas_n = cmd_q[1];
   assign sd_we_n = cmd_q[0];
   assign sd_ba = ba_q;
   assign sd_addr = a_q;
   assign sd_dqm = dqm_q;
   assign sd_dq_out = dq_q;
   assign sd_dq_oe = oe_q;
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign sr_active = sr_q;
   assign init_done = done_q;
endmodule : sdc_ctrl

// *** sdc_ctrl_note_placeholder.sv ***
`timescale 1ns/10ps

// *** sdc_ctrl_sva.sv ***
`timescale 1ns/10ps
module sdc_ctrl_sva
   import sdc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Watched outputs
   input wire logic init_done,
   input wire logic rd_valid,
   input wire logic sd_cke,
   input wire logic sd_cs_n,
   input wire logic sd_ras_n,
   input wire logic sd_cas_n,
   input wire logic sd_we_n,
   input wire logic [ROW_W-1:0] sd_addr,
   input wire logic sd_dq_oe
);
   wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   logic [7:0] xsr_q;
   logic [11:0] ref_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Cycles since clock enable came back
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) xsr_q <= 8'hFF;
      else if (!sd_cke) xsr_q <= 8'h00;
      else if (xsr_q != 8'hFF) xsr_q <= xsr_q + 8'h01;
   end
   // A pending refresh may wait out one access, hence the slack
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) ref_q <= 12'h000;
      else if (cmd == CMD_REF || !sd_cke || !init_done) ref_q <= 12'h000;
      else ref_q <= ref_q + 12'h001;
   end
   property p_row_col;
      (cmd == CMD_ACT) |=> (cmd != CMD_RD && cmd != CMD_WR) [*3]
         ##1 (cmd == CMD_RD || cmd == CMD_WR);
   endproperty
   a_row_col: assert property (p_row_col)
      else $error("column command not four cycles after activate");
   property p_act_gap;
      (cmd == CMD_ACT) |=> (cmd != CMD_ACT);
   endproperty
   a_act_gap: assert property (p_act_gap)
      else $error("activates too close");
   property p_sr_exit;
      (cmd != CMD_NOP && sd_cke) |-> (xsr_q >= SR_EXIT_CYC);
   endproperty
   a_sr_exit: assert property (p_sr_exit)
      else $error("command too soon after self refresh exit");
   property p_ap_act;
      (cmd == CMD_WR && sd_addr[AP_BIT]) |=> (cmd != CMD_ACT) [*4];
   endproperty
   a_ap_act: assert property (p_ap_act)
      else $error("activate too soon after auto precharge write");
   property p_wr_pre;
      (cmd == CMD_WR) |=> (cmd != CMD_PRE);
   endproperty
   a_wr_pre: assert property (p_wr_pre)
      else $error("precharge too soon after write data");
   property p_wr_data;
      (cmd == CMD_WR) |-> sd_dq_oe ##1 !sd_dq_oe;
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data not driven with write command only");
   property p_mode_gap;
      (cmd == CMD_MRS) |-> init_done ##1 (cmd != CMD_ACT && cmd != CMD_REF);
   endproperty
   a_mode_gap: assert property (p_mode_gap)
      else $error("command too soon after mode load");
   property p_ref_int;
      ref_q <= REFI_CYC + 40;
   endproperty
   a_ref_int: assert property (p_ref_int)
      else $error("refresh interval exceeded");
   property p_rd_lat;
      (cmd == CMD_RD) |-> ##4 rd_valid;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late or missing");
endmodule : sdc_ctrl_sva

bind sdc_ctrl sdc_ctrl_sva sdc_ctrl_sva_inst (
   .core_clk(core_clk), .arst_n(arst_n), .init_done(init_done),
   .rd_valid(rd_valid), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
   .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
   .sd_addr(sd_addr), .sd_dq_oe(sd_dq_oe));

// *** sdc_mem_model.sv ***
`timescale 1ns/10ps
module sdc_mem_model
   import sdc_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Command pins
   input wire logic sd_cke,
   input wire logic sd_cs_n,
   input wire logic sd_ras_n,
   input wire logic sd_cas_n,
   input wire logic sd_we_n,
   input wire logic [BA_W-1:0] sd_ba,
   input wire logic [ROW_W-1:0] sd_addr,
   // Data pins
   input wire logic [DM_W-1:0] sd_dqm,
   input wire logic [DQ_W-1:0] sd_dq_out,
   input wire logic sd_dq_oe,
   output logic [DQ_W-1:0] sd_dq_in
);
   logic [DQ_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [ROW_W-1:0] row_q [4];
   logic [ADDR_W-1:0] key, a1_q, a2_q;
   logic [DQ_W-1:0] word;
   logic [DM_W-1:0] m1_q;
   logic cke_q = 1'b1;
   logic p1_q = 1'b0;
   logic p2_q = 1'b0;
   initial sd_dq_in = 16'h5A5A;
   always @(posedge core_clk) begin
      key = {sd_ba, row_q[sd_ba], sd_addr[COL_W-1:0]};
      word = mem.exists(key) ? mem[key] : 16'h0000;
      cke_q <= sd_cke;
      m1_q <= sd_dqm;
      p1_q <= 1'b0;
      p2_q <= p1_q;
      a2_q <= a1_q;
      // Clock enable gates the edge after it is sampled
      if (cke_q) begin
         case ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n})
            CMD_ACT: row_q[sd_ba] <= sd_addr;
            CMD_WR: begin
               for (int i = 0; i < DM_W; i++)
                  if (!sd_dqm[i] && sd_dq_oe) word[8*i+:8] = sd_dq_out[8*i+:8];
               mem[key] = word;
            end
            CMD_RD: begin
               p1_q <= 1'b1;
               a1_q <= key;
            end
            default: ;
         endcase
      end
      if (p2_q) begin
         word = mem.exists(a2_q) ? mem[a2_q] : 16'h0000;
         for (int i = 0; i < DM_W; i++)
            if (m1_q[i]) word[8*i+:8] = ~sd_dq_in[8*i+:8];
         sd_dq_in <= word;
      end
      // Burst of one: afterwards the bus floats, shown as a toggle
      else sd_dq_in <= ~sd_dq_in;
   end
endmodule : sdc_mem_model

// *** sdc_ctrl_tb.sv ***
`timescale 1ns/10ps
module sdc_ctrl_tb
   import sdc_pkg::*;
;
   logic core_clk, ce, arst_n, req_valid, req_write, sr_req, req_ready;
   logic rd_valid, sr_active, init_done, sd_cke, sd_cs_n, sd_ras_n;
   logic sd_cas_n, sd_we_n, sd_dq_oe;
   logic [ADDR_W-1:0] req_addr;
   logic [DQ_W-1:0] req_wdata, rd_data, sd_dq_out, sd_dq_in;
   logic [DM_W-1:0] req_mask, sd_dqm, wr_dqm;
   logic [BA_W-1:0] sd_ba;
   logic [ROW_W-1:0] sd_addr;
   logic [DQ_W-1:0] rq[$];
   int bad_count, comparisons, ref_n;
   wire logic [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
   sdc_ctrl #(.INIT_WAIT_CYC(10)) sdc_ctrl_inst (
      .core_clk(core_clk), .ce(ce), .arst_n(arst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
      .rd_valid(rd_valid), .rd_data(rd_data), .sr_req(sr_req),
      .sr_active(sr_active), .init_done(init_done), .sd_cke(sd_cke),
      .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
      .sd_we_n(sd_we_n), .sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dqm(sd_dqm),
      .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in));
   sdc_mem_model sdc_mem_model_inst (
      .core_clk(core_clk), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
      .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
      .sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dqm(sd_dqm),
      .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (cmd === CMD_WR) wr_dqm <= sd_dqm;
      if (cmd === CMD_REF && sd_cke === 1'b1) ref_n++;
   end
   task tick;
      @(posedge core_clk);
      #1;
   endtask : tick
   task chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Leaves valid high so back-to-back pushes need no gap
   task push(input logic w, input logic [ADDR_W-1:0] a,
             input logic [DQ_W-1:0] d, input logic [DM_W-1:0] m);
      int n;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_mask = m;
      req_valid = 1'b1;
      for (n = 0; n < 100 && req_ready !== 1'b1; n++) tick;
      tick;
   endtask : push
   task wait_rd(input int k);
      for (int n = 0; n < 400 && rq.size() < k; n++) tick;
      chk("read count", k, rq.size());
   endtask : wait_rd
   task t_init;
      repeat (20) @(posedge core_clk);
      chk("ready in reset", 0, req_ready);
      chk("dqm in reset", 2'h3, sd_dqm);
      #1 arst_n = 1'b1;
      for (int n = 0; n < 200 && init_done !== 1'b1; n++) tick;
      chk("init done", 1, init_done);
      $display("t_init done");
   endtask : t_init
   task t_write_read;
      rq.delete();
      push(1'b1, 24'h000010, 16'hA55A, 2'h0);
      push(1'b1, 24'h000010, 16'h1234, 2'h1);
      push(1'b0, 24'h000010, 16'h0000, 2'h0);
      req_valid = 1'b0;
      wait_rd(1);
      chk("write mask pins", 2'h1, wr_dqm);
      chk("masked word", 16'h125A, rq.pop_front());
      $display("t_write_read done");
   endtask : t_write_read
   task t_banks;
      rq.delete();
      for (int b = 0; b < 4; b++) push(1'b1, {b[1:0], 22'h000123},
         16'h1000 + b[15:0], 2'h0);
      for (int b = 0; b < 4; b++) push(1'b0, {b[1:0], 22'h000123},
         16'h0000, 2'h0);
      req_valid = 1'b0;
      wait_rd(4);
      for (int b = 0; b < 4; b++)
         chk("bank word", 16'h1000 + b, rq.pop_front());
      $display("t_banks done");
   endtask : t_banks
   // Self refresh stalls service, so the buffer fills and refuses
   task t_fill_sr;
      rq.delete();
      sr_req = 1'b1;
      for (int n = 0; n < 100 && sr_active !== 1'b1; n++) tick;
      chk("cke in self refresh", 0, sd_cke);
      for (int b = 0; b < 4; b++) push(1'b0, {b[1:0], 22'h000123},
         16'h0000, 2'h0);
      req_valid = 1'b0;
      chk("buffer full", 0, req_ready);
      chk("held reads", 0, rq.size());
      sr_req = 1'b0;
      wait_rd(4);
      for (int b = 0; b < 4; b++)
         chk("drained word", 16'h1000 + b, rq.pop_front());
      chk("sr exit", 0, sr_active);
      chk("cke after exit", 1, sd_cke);
      $display("t_fill_sr done");
   endtask : t_fill_sr
   // A frozen controller must neither take nor serve a request
   task t_clk_gate;
      rq.delete();
      ce = 1'b0;
      req_write = 1'b0;
      req_addr = 24'h000123;
      req_valid = 1'b1;
      repeat (16) tick;
      chk("gated reads", 0, rq.size());
      chk("gated cke", 1, sd_cke);
      ce = 1'b1;
      tick;
      req_valid = 1'b0;
      wait_rd(1);
      chk("gated word", 16'h1000, rq.pop_front());
      $display("t_clk_gate done");
   endtask : t_clk_gate
   task t_refresh;
      int n0;
      n0 = ref_n;
      repeat (1700) tick;
      chk("idle refresh", 1, (ref_n - n0) >= 1);
      $display("t_refresh done");
   endtask : t_refresh
   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      #100000;
      bad_count++;
      give_verdict;
   end
   initial begin
      {ce, arst_n, req_valid, req_write, sr_req} = 5'h10;
      req_addr = 24'h000000;
      req_wdata = 16'h0000;
      req_mask = 2'h0;
      t_init;
      t_write_read;
      t_banks;
      t_fill_sr;
      t_clk_gate;
      t_refresh;
      give_verdict;
   end
endmodule : sdc_ctrl_tb
